//--- mw_wakeup.sv
// multi-input wakeup, port interrupt and start-up delay with an AXI4-Lite register slave
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`include "mw_map.svh"
`timescale 1ns/1ns
`default_nettype none

module mw_wakeup (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  // register bus
  input wire mw_pkg::mw_axi_req_s axi_req,
  output var mw_pkg::mw_axi_rsp_s axi_rsp,
  // pins
  input wire logic [7:0] wake_pin,
  input wire logic clock_out_pin,
  input wire logic reset_pin_n,
  // power and interrupt
  output logic osc_enable,
  output logic core_clk_enable,
  output logic port_irq,
  output logic resume_to_isr,
  output var mw_pkg::mw_pwr_e power_state
);

  mw_pkg::mw_state_s s_q;
  mw_pkg::mw_state_s s_d;
  logic [7:0] edge_ev;

  // per-pin trigger on the synchronised pin
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_edge
      assign edge_ev[gi] = s_q.edg[gi] ? (s_q.prev[gi] & ~s_q.sync2[gi])
                                       : (~s_q.prev[gi] & s_q.sync2[gi]);
    end
  endgenerate

  always_comb begin
    logic wr_go;
    logic wr_hit;
    logic rd_hit;
    logic [7:0] pend_wr;
    logic armed;
    logic wake;
    logic need_dly;
    logic [7:0] rbyte;
    wr_go = 1'b0;
    wr_hit = 1'b0;
    rd_hit = 1'b0;
    pend_wr = s_q.pend;
    armed = 1'b0;
    wake = 1'b0;
    need_dly = 1'b0;
    rbyte = `MW_RST_BYTE;
    s_d = s_q;

    // two-flop synchronisers and edge history
    s_d.sync1 = wake_pin;
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;
    s_d.ck1 = clock_out_pin;
    s_d.ck2 = s_q.ck1;
    s_d.ckprev = s_q.ck2;
    s_d.rp1_n = reset_pin_n;
    s_d.rp2_n = s_q.rp1_n;

    // write address and data, taken in either order
    if (axi_req.awvalid && s_q.rsp.awready) begin
      s_d.aw_addr = axi_req.awaddr;
      s_d.rsp.awready = 1'b0;
    end
    if (axi_req.wvalid && s_q.rsp.wready) begin
      s_d.w_data = axi_req.wdata[7:0];
      s_d.w_lane0 = axi_req.wstrb[0];
      s_d.rsp.wready = 1'b0;
    end
    wr_go = !s_q.rsp.awready && !s_q.rsp.wready && !s_q.rsp.bvalid;
    if (wr_go) begin
      wr_hit = 1'b1;
      unique case (s_q.aw_addr)
        `MW_OFF_ENABLE: begin
          if (s_q.w_lane0) s_d.en = s_q.w_data;
        end
        `MW_OFF_EDGE: begin
          if (s_q.w_lane0) s_d.edg = s_q.w_data;
        end
        `MW_OFF_PEND: begin
          if (s_q.w_lane0) pend_wr = s_q.w_data;
        end
        `MW_OFF_CTRL: begin
          if (s_q.w_lane0) begin
            s_d.port_wake_irq_enable = s_q.w_data[`MW_CTRL_PORT_WAKE_IRQ_ENABLE];
            s_d.global_irq_enable = s_q.w_data[`MW_CTRL_GIE];
            s_d.dly_sel = s_q.w_data[`MW_CTRL_DLY];
            s_d.rc_mode = s_q.w_data[`MW_CTRL_RC];
          end
        end
        `MW_OFF_STAT, `MW_OFF_TIMER: ;
        default: wr_hit = 1'b0;
      endcase
      s_d.rsp.bvalid = 1'b1;
      s_d.rsp.bresp = wr_hit ? `MW_RESP_OKAY : `MW_RESP_SLVERR;
    end
    if (s_q.rsp.bvalid && axi_req.bready) begin
      s_d.rsp.bvalid = 1'b0;
      s_d.rsp.awready = 1'b1;
      s_d.rsp.wready = 1'b1;
    end

    // pending: software write, then edges win over any clear
    s_d.pend = pend_wr | edge_ev;
    armed = |(s_q.en & s_q.pend);

    // read channel
    if (axi_req.arvalid && s_q.rsp.arready) begin
      rd_hit = 1'b1;
      unique case (axi_req.araddr)
        `MW_OFF_ENABLE: rbyte = s_q.en;
        `MW_OFF_EDGE: rbyte = s_q.edg;
        `MW_OFF_PEND: rbyte = s_q.pend;
        `MW_OFF_CTRL: begin
          rbyte[`MW_CTRL_PORT_WAKE_IRQ_ENABLE] = s_q.port_wake_irq_enable;
          rbyte[`MW_CTRL_GIE] = s_q.global_irq_enable;
          rbyte[`MW_CTRL_DLY] = s_q.dly_sel;
          rbyte[`MW_CTRL_RC] = s_q.rc_mode;
        end
        `MW_OFF_STAT: rbyte = {2'h0, s_q.isr_first, s_q.irq, s_q.core_clk_en,
                               s_q.osc_en, s_q.pwr};
        `MW_OFF_TIMER: rbyte = s_q.timer[7:0];
        default: rd_hit = 1'b0;
      endcase
      s_d.rsp.arready = 1'b0;
      s_d.rsp.rvalid = 1'b1;
      s_d.rsp.rdata = {24'h000000, rbyte};
      s_d.rsp.rresp = rd_hit ? `MW_RESP_OKAY : `MW_RESP_SLVERR;
    end
    if (s_q.rsp.rvalid && axi_req.rready) begin
      s_d.rsp.rvalid = 1'b0;
      s_d.rsp.arready = 1'b1;
    end

    // shared port interrupt request
    s_d.irq = armed && s_q.port_wake_irq_enable && s_q.global_irq_enable;

    // power sequencing
    need_dly = !s_q.rc_mode || s_q.dly_sel;
    unique case (s_q.pwr)
      mw_pkg::MW_RUN: begin
        if (wr_go && s_q.aw_addr == `MW_OFF_CTRL && s_q.w_lane0) begin
          if (s_q.w_data[`MW_CTRL_HALT] && !armed) begin
            s_d.pwr = mw_pkg::MW_HALT;
            s_d.osc_en = 1'b0;
            s_d.core_clk_en = 1'b0;
          end else if (s_q.w_data[`MW_CTRL_IDLE]) begin
            s_d.pwr = mw_pkg::MW_IDLE;
            s_d.core_clk_en = 1'b0;
          end
        end
      end
      mw_pkg::MW_HALT, mw_pkg::MW_IDLE: begin
        wake = |(s_q.en & edge_ev) || !s_q.rp2_n;
        if (s_q.pwr == mw_pkg::MW_HALT && s_q.rc_mode && s_q.ck2 && !s_q.ckprev) begin
          wake = 1'b1;
        end
        if (wake) begin
          s_d.isr_first = s_q.port_wake_irq_enable && s_q.global_irq_enable;
          s_d.osc_en = 1'b1;
          if (need_dly) begin
            s_d.pwr = mw_pkg::MW_START;
            s_d.timer = `MW_TIMER_LOAD;
          end else begin
            s_d.pwr = mw_pkg::MW_RUN;
            s_d.core_clk_en = 1'b1;
          end
        end
      end
      mw_pkg::MW_START: begin
        s_d.timer = s_q.timer - `MW_TIMER_ONE;
        if (s_q.timer == `MW_TIMER_ONE) begin
          s_d.pwr = mw_pkg::MW_RUN;
          s_d.core_clk_en = 1'b1;
        end
      end
    endcase

    if (!clk_en) begin
      s_d = s_q;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.prev <= 8'hFF;
      s_q.sync1 <= 8'hFF;
      s_q.sync2 <= 8'hFF;
      s_q.ckprev <= 1'b1;
      s_q.ck1 <= 1'b1;
      s_q.ck2 <= 1'b1;
      s_q.rp1_n <= 1'b1;
      s_q.rp2_n <= 1'b1;
      s_q.osc_en <= 1'b1;
      s_q.core_clk_en <= 1'b1;
      s_q.rsp.awready <= 1'b1;
      s_q.rsp.wready <= 1'b1;
      s_q.rsp.arready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign axi_rsp = s_q.rsp;
  assign osc_enable = s_q.osc_en;
  assign core_clk_enable = s_q.core_clk_en;
  assign port_irq = s_q.irq;
  assign resume_to_isr = s_q.isr_first;
  assign power_state = s_q.pwr;

endmodule

`default_nettype wire

//--- mw_map.svh
// register offsets, field positions, reset values and timing counts for the wakeup block
`ifndef MW_MAP_SVH
`define MW_MAP_SVH

`define MW_OFF_ENABLE 8'h00
`define MW_OFF_EDGE 8'h04
`define MW_OFF_PEND 8'h08
`define MW_OFF_CTRL 8'h0C
`define MW_OFF_STAT 8'h10
`define MW_OFF_TIMER 8'h14

`define MW_CTRL_PORT_WAKE_IRQ_ENABLE 0
`define MW_CTRL_GIE 1
`define MW_CTRL_DLY 2
`define MW_CTRL_RC 3
`define MW_CTRL_HALT 4
`define MW_CTRL_IDLE 5

`define MW_RST_BYTE 8'h00
`define MW_TIMER_LOAD 9'h100
`define MW_TIMER_ONE 9'h001
`define MW_TIMER_ZERO 9'h000

`define MW_RESP_OKAY 2'h0
`define MW_RESP_SLVERR 2'h2

`endif

//--- mw_pkg.sv
// types shared by the wakeup block
`default_nettype none

package mw_pkg;

  typedef enum logic [1:0] {
    MW_RUN = 2'b00,
    MW_HALT = 2'b01,
    MW_IDLE = 2'b10,
    MW_START = 2'b11
  } mw_pwr_e;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } mw_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } mw_axi_rsp_s;

  typedef struct packed {
    logic [7:0] en;
    logic [7:0] edg;
    logic [7:0] pend;
    logic port_wake_irq_enable;
    logic global_irq_enable;
    logic dly_sel;
    logic rc_mode;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] prev;
    logic ck1;
    logic ck2;
    logic ckprev;
    logic rp1_n;
    logic rp2_n;
    mw_pwr_e pwr;
    logic [8:0] timer;
    logic osc_en;
    logic core_clk_en;
    logic irq;
    logic isr_first;
    logic [7:0] aw_addr;
    logic [7:0] w_data;
    logic w_lane0;
    mw_axi_rsp_s rsp;
  } mw_state_s;

endpackage

`default_nettype wire

//--- mw_wakeup_checker.sv
// port assertions for the wakeup block
`timescale 1ns/1ns
`default_nettype none
module mw_wakeup_checker (
  // clock, reset and enable
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  // register bus
  input wire mw_pkg::mw_axi_req_s axi_req,
  input wire mw_pkg::mw_axi_rsp_s axi_rsp,
  // pins
  input wire logic [7:0] wake_pin,
  input wire logic clock_out_pin,
  input wire logic reset_pin_n,
  // power and interrupt
  input wire logic osc_enable,
  input wire logic core_clk_enable,
  input wire logic port_irq,
  input wire logic resume_to_isr,
  input wire mw_pkg::mw_pwr_e power_state
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic [8:0] n_q;
  logic st;
  logic sl;
  assign st = power_state == mw_pkg::MW_START;
  assign sl = power_state inside {mw_pkg::MW_HALT, mw_pkg::MW_IDLE};
  // cycles spent in start-up
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      n_q <= 9'h000;
    end else begin
      n_q <= st ? n_q + 9'h001 : 9'h000;
    end
  end
  halt_clk_a: assert property (power_state == mw_pkg::MW_HALT |-> !osc_enable && !core_clk_enable)
    else $error("clocks on in halt");
  start_osc_a: assert property (st |-> osc_enable && !core_clk_enable)
    else $error("bad clocks in start-up");
  start_len_a: assert property ($fell(st) |-> n_q == 9'h100)
    else $error("start-up length wrong");
  start_end_a: assert property ($fell(st) |-> power_state == mw_pkg::MW_RUN && core_clk_enable)
    else $error("start-up end wrong");
  resume_irq_a: assert property (sl ##1 !sl |=> resume_to_isr == port_irq)
    else $error("resume flag differs");
  halt_refuse_a: assert property (port_irq |-> power_state != mw_pkg::MW_HALT)
    else $error("halt while pending");
  wr_resp_a: assert property (axi_req.awvalid && axi_req.wvalid && axi_rsp.awready && axi_rsp.wready |-> ##2 axi_rsp.bvalid)
    else $error("late write response");
  rd_resp_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("late read data");
endmodule
`default_nettype wire

//--- mw_pin_model.sv
// port pin driver standing in for the outside wiring
`timescale 1ns/1ns
`default_nettype none
module mw_pin_model (
  // clock
  input wire logic clk_sys,
  // wanted levels and lag select
  input wire logic [9:0] want,
  input wire logic slow,
  // pins
  output logic [7:0] wake_pin,
  output logic clock_out_pin,
  output logic reset_pin_n
);
  logic [9:0] lag_q;
  always_ff @(posedge clk_sys) begin
    lag_q <= want;
  end
  // slow pins settle one cycle later
  assign {reset_pin_n, clock_out_pin, wake_pin} = slow ? lag_q : want;
endmodule
`default_nettype wire

//--- mw_wakeup_bench.sv
// self-checking bench for the wakeup block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fails++; \
  $display("wrong value %0t got %h", $time, a); end end
module mw_wakeup_bench;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  mw_pkg::mw_axi_req_s rq = '0;
  mw_pkg::mw_axi_rsp_s rs;
  logic [9:0] want = 10'h2FF;
  logic slow = 1'b0;
  logic [7:0] pin;
  logic ck;
  logic rpn;
  logic [33:0] q[$];
  int fails = 0;
  int n_compared = 0;
  integer seed = 72;
  logic [7:0] c, r, e, m;
  always #4 clk_sys = ~clk_sys;
  mw_wakeup i_mw_wakeup (.clk_sys(clk_sys), .resetn(resetn), .clk_en(1'b1), .axi_req(rq),
    .axi_rsp(rs), .wake_pin(pin), .clock_out_pin(ck), .reset_pin_n(rpn), .osc_enable(),
    .core_clk_enable(), .port_irq(), .resume_to_isr(), .power_state());
  mw_pin_model i_mw_pin_model (.clk_sys(clk_sys), .want(want), .slow(slow), .wake_pin(pin),
    .clock_out_pin(ck), .reset_pin_n(rpn));
  always @(posedge clk_sys) begin
    if (rs.rvalid && rq.rready) `CHK({rs.rresp, rs.rdata}, q.pop_front())
    if (rs.bvalid && rq.bready) `CHK({rs.bresp, 32'h0}, q.pop_front())
  end
  task automatic finish_test;
    if (fails == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [33:0] x);
    int k;
    q.push_back(x);
    rq.awaddr <= a;
    rq.araddr <= a;
    rq.wdata <= d;
    rq.wstrb <= 4'hF;
    {rq.awvalid, rq.wvalid, rq.bready} <= {3{w}};
    {rq.arvalid, rq.rready} <= {2{!w}};
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys);
      if (rs.awready) rq.awvalid <= 1'b0;
      if (rs.wready) rq.wvalid <= 1'b0;
      if (rs.arready) rq.arvalid <= 1'b0;
      if (rs.bvalid || rs.rvalid) break;
    end
    {rq.bready, rq.rready} <= 2'b00;
    // let an edge pass so a following call never re-raises ready in this step
    @(posedge clk_sys);
    if (k == 50) begin
      fails++;
      finish_test;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xf(1'b1, a, {24'($random(seed)), d}, 34'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    xf(1'b0, a, 32'h0, {26'h0, x});
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  initial begin
    tk(6);
    resetn <= 1'b1;
    tk(1);
    for (int i = 0; i < 4; i++) rd(8'(i * 4), 8'h00);
    rd(8'h10, 8'h0C);
    for (int i = 0; i < 3; i++) begin
      e = 8'($random(seed));
      wr(8'(i * 4), e);
      rd(8'(i * 4), e);
    end
    xf(1'b1, 8'h18, 32'h0, {2'h2, 32'h0});
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      c = {4'h0, i[2], i[1], i[0], i[0]};
      m = 8'h01 << i;
      e = 8'($random(seed)) & m;
      wr(8'h00, 8'h00);
      wr(8'h04, e);
      want[i] <= e[i];
      slow <= 1'($random(seed));
      tk(5);
      wr(8'h08, 8'h00);
      wr(8'h00, m);
      wr(8'h0C, c | 8'h10);
      rd(8'h0C, c);
      rd(8'h10, 8'h01 | r);
      want[i] <= !e[i];
      tk(5);
      r = c[0] ? 8'h20 : 8'h00;
      rd(8'h10, (c[3] && !c[2] ? 8'h0C : 8'h07) | r | r >> 1);
      rd(8'h08, m);
      tk(260);
      rd(8'h10, 8'h0C | r | r >> 1);
      wr(8'h0C, c | 8'h10);
      rd(8'h10, 8'h0C | r | r >> 1);
      want[i] <= 1'b1;
      tk(5);
      rd(8'h08, m);
    end
    wr(8'h08, 8'h00);
    wr(8'h0C, 8'h18);
    rd(8'h10, 8'h01 | r);
    want[8] <= 1'b1;
    tk(5);
    rd(8'h10, 8'h0C);
    want[8] <= 1'b0;
    wr(8'h0C, 8'h20);
    rd(8'h10, 8'h06);
    want[9] <= 1'b0;
    tk(5);
    rd(8'h10, 8'h07);
    want[9] <= 1'b1;
    tk(260);
    rd(8'h10, 8'h0C);
    finish_test;
  end
endmodule
bind mw_wakeup mw_wakeup_checker i_mw_wakeup_checker (.clk_sys(clk_sys), .resetn(resetn),
  .clk_en(clk_en), .axi_req(axi_req), .axi_rsp(axi_rsp), .wake_pin(wake_pin),
  .clock_out_pin(clock_out_pin), .reset_pin_n(reset_pin_n), .osc_enable(osc_enable),
  .core_clk_enable(core_clk_enable), .port_irq(port_irq), .resume_to_isr(resume_to_isr),
  .power_state(power_state));
`default_nettype wire
